// ### car_bank_pkg.sv
package car_bank_pkg;
  localparam int          REG_W            = 32;
  localparam int          OFF_W            = 24;
  localparam int          REV_W            = 16;
  localparam logic [23:0] OFF_ASSEMBLY_INFO = 24'h00000C;
  localparam logic [23:0] OFF_FEATURES      = 24'h000010;
  localparam logic [3:0]  FTYPE_MAINT       = 4'h8;
  localparam logic [7:0]  HOP_LOCAL         = 8'h00;
  localparam logic [15:0] ASM_REV_RESET     = 16'h0000;
  localparam logic [15:0] FEATURE_LIST_PTR  = 16'h0100;
  // big-endian numbering: documented bit n sits at vector bit 31-n
  localparam int          BIT_BRIDGE       = 31;
  localparam int          BIT_MEMORY       = 30;
  localparam int          BIT_PROCESSOR    = 29;
  localparam int          BIT_SWITCH       = 28;
  localparam int          BIT_MULTICAST    = 10;
  localparam int          REV_HI           = 31;
  localparam int          REV_LO           = 16;
  // fields beyond the flags above, taken from the register's reset value
  localparam logic [31:0] FEATURES_OTHER    = 32'h0000011F;
  localparam logic [31:0] FEATURES_RESET    = 32'h1000051F;
  localparam logic [31:0] READ_ZERO         = 32'h00000000;
endpackage : car_bank_pkg

// ### revision_if.sv
`timescale 1ns/1ns
interface revision_if;
  import car_bank_pkg::*;
  logic             preload_valid;
  logic [REV_W-1:0] preload_value;
  logic             soft_reset;
  logic [REV_W-1:0] revision;
  logic             boot_open;
  modport owner (input preload_valid, input preload_value, input soft_reset,
                 output revision, output boot_open);
  modport user  (output preload_valid, output preload_value, output soft_reset,
                 input revision, input boot_open);
endinterface : revision_if

// ### assembly_revision_store.sv
`timescale 1ns/1ns
module assembly_revision_store (
  input wire logic    clk_sys,  // system clock
  input wire logic    rstn,     // power-on reset, async, active low
  input wire logic    ce,       // clock enable
  revision_if.owner   rev       // preload and revision
);
  import car_bank_pkg::*;

  typedef struct packed {
    logic [REV_W-1:0] value;
    logic             boot_open;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (rev.soft_reset) begin
      // soft resets never reopen the loading window; loaded value survives
      s_d.boot_open = 1'b0;
    end else if (s_q.boot_open && rev.preload_valid) begin
      s_d.value     = rev.preload_value;
      s_d.boot_open = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q.value     <= ASM_REV_RESET;
      s_q.boot_open <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rev.revision  = s_q.value;
  assign rev.boot_open = s_q.boot_open;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_soft_no_load: assert property ((ce && rev.soft_reset) |=> !rev.boot_open)
    else $error("soft reset left the preload window open");
  a_preload_taken: assert property (
      (ce && rev.boot_open && rev.preload_valid && !rev.soft_reset)
      |=> rev.revision == $past(rev.preload_value))
    else $error("preload value not stored");
  a_closed_stays: assert property (!rev.boot_open |=> !rev.boot_open)
    else $error("preload window reopened without power-on reset");
  a_closed_frozen: assert property (!rev.boot_open |=> $stable(rev.revision))
    else $error("revision changed after preload window closed");
  c_preload: cover property (rev.boot_open && rev.preload_valid && ce);
endmodule : assembly_revision_store

// ### switch_capability_car_bank.sv
`timescale 1ns/1ns
module switch_capability_car_bank
  import car_bank_pkg::*;
(
  input  wire logic                          clk_sys,        // system clock, 20 MHz
  input  wire logic                          rstn,           // power-on reset, async low
  input  wire logic                          ce,             // clock enable
  input  wire logic                          soft_reset,     // self or port reset pulse
  input  wire logic                          port_powered_down, // owning port is off
  input  wire logic                          preload_valid,  // EEPROM revision word valid
  input  wire logic [car_bank_pkg::REV_W-1:0] preload_value, // EEPROM revision word
  input  wire logic                          req_valid,      // maintenance packet valid
  input  wire logic [3:0]                    req_ftype,      // packet format type
  input  wire logic [7:0]                    req_hop_count,  // remaining hop count
  input  wire logic                          req_write,      // write request
  input  wire logic [car_bank_pkg::OFF_W-1:0] req_offset,    // register byte offset
  input  wire logic [car_bank_pkg::REG_W-1:0] req_wdata,     // write data, ignored
  output logic                               resp_valid,     // answer pulse
  output logic                               resp_write,     // answer is for a write
  output logic [car_bank_pkg::REG_W-1:0]     resp_data,      // read data
  output logic                               route_valid     // packet not for us, pass on
);
  import car_bank_pkg::*;

  typedef struct packed {
    logic             resp_valid;
    logic             resp_write;
    logic [REG_W-1:0] resp_data;
    logic             route_valid;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;
  logic        local_hit;
  logic [REG_W-1:0] asm_word;
  logic [REG_W-1:0] feat_word;

  revision_if rev_bus ();

  assign rev_bus.preload_valid = preload_valid;
  assign rev_bus.preload_value = preload_value;
  assign rev_bus.soft_reset    = soft_reset;

  assembly_revision_store u_rev (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .rev     (rev_bus.owner)
  );

  // decode used by the read mux only; the checks below do not call it
  function automatic logic [REG_W-1:0] read_word(input logic [OFF_W-1:0] off,
                                                 input logic [REG_W-1:0] asm,
                                                 input logic [REG_W-1:0] feat);
    logic [REG_W-1:0] w;
    w = READ_ZERO;
    if (off == OFF_ASSEMBLY_INFO) begin
      w = asm;
    end else if (off == OFF_FEATURES) begin
      w = feat;
    end
    return w;
  endfunction : read_word

  always_comb begin
    asm_word                = READ_ZERO;
    asm_word[REV_HI:REV_LO] = rev_bus.revision;
    asm_word[REV_W-1:0]     = FEATURE_LIST_PTR;
  end

  always_comb begin
    feat_word                = FEATURES_OTHER;
    feat_word[BIT_BRIDGE]    = 1'b0;
    feat_word[BIT_MEMORY]    = 1'b0;
    feat_word[BIT_PROCESSOR] = 1'b0;
    feat_word[BIT_SWITCH]    = 1'b1;
    feat_word[BIT_MULTICAST] = 1'b1;
  end

  assign local_hit = req_valid && req_ftype == FTYPE_MAINT && req_hop_count == HOP_LOCAL;

  always_comb begin
    s_d             = s_q;
    s_d.resp_valid  = local_hit;
    s_d.resp_write  = local_hit && req_write;
    s_d.route_valid = req_valid && !local_hit;
    s_d.resp_data   = READ_ZERO;
    // writes get an answer but no field moves; answer data stays zero
    if (local_hit && !req_write && !port_powered_down) begin
      s_d.resp_data = read_word(req_offset, asm_word, feat_word);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign resp_valid  = s_q.resp_valid;
  assign resp_write  = s_q.resp_write;
  assign resp_data   = s_q.resp_data;
  assign route_valid = s_q.route_valid;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence local_read_of(logic [OFF_W-1:0] off);
    ce && local_hit && !req_write && !port_powered_down && req_offset == off;
  endsequence

  // assembly information word
  a_asm_word_read: assert property (
      local_read_of(OFF_ASSEMBLY_INFO) |=>
      resp_valid && resp_data[REV_W-1:0] == 16'h0100 &&
      resp_data[REV_HI:REV_LO] == $past(rev_bus.revision))
    else $error("assembly info read wrong");
  a_rev_field: assert property (
      local_read_of(OFF_ASSEMBLY_INFO) |=>
      resp_data[REV_HI:REV_LO] == $past(rev_bus.revision))
    else $error("revision field wrong");
  a_rev_default: assert property (
      rev_bus.boot_open |->
      rev_bus.revision == 16'h0000)
    else $error("revision not zero before preload");

  // features word, flag by flag
  a_feat_flags: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data[31:28] == 4'h1)
    else $error("bridge, memory, processor or switch flag wrong");
  a_feat_word: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data == 32'h1000051F)
    else $error("features word wrong");
  a_bridge_clear: assert property (
      local_read_of(OFF_FEATURES) |=>
      !resp_data[31])
    else $error("bridge flag set");
  a_no_mem_processor_flag: assert property (
      local_read_of(OFF_FEATURES) |=>
      !resp_data[30] && !resp_data[29])
    else $error("memory or processor flag set");
  a_processor_flag_clear: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data[29] == 1'b0)
    else $error("processor flag set");
  a_switch_set: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data[28])
    else $error("switch flag clear");
  a_mcast_set: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data[10])
    else $error("multicast flag clear");
  a_reserved_zero: assert property (
      local_read_of(OFF_FEATURES) |=>
      resp_data[27:11] == 17'h00000 && !resp_data[9] &&
      resp_data[7:5] == 3'h0)
    else $error("reserved features bit set");

  // steering and answer shape
  a_local_route: assert property (
      (ce && req_valid) |=>
      (resp_valid ^ route_valid) &&
      (resp_valid == $past(req_ftype == 4'h8 && req_hop_count == 8'h00)))
    else $error("maintenance packet steered wrong");
  a_ftype_only: assert property (
      (ce && req_valid && req_ftype != 4'h8) |=>
      !resp_valid && route_valid)
    else $error("non-maintenance packet answered locally");
  a_hop_only: assert property (
      (ce && req_valid && req_hop_count != 8'h00) |=>
      !resp_valid && route_valid)
    else $error("packet with hops left answered locally");
  a_route_no_data: assert property (
      (ce && req_valid && !local_hit) |=>
      !resp_write && resp_data == 32'h00000000)
    else $error("passed-on packet carried answer data");
  a_no_req_quiet: assert property (
      (ce && !req_valid) |=>
      !resp_valid && !route_valid && !resp_write)
    else $error("answer without a request");
  a_read_answer: assert property (
      (ce && local_hit && !req_write) |=>
      resp_valid && !resp_write && !route_valid)
    else $error("read answered with wrong flags");
  a_write_answer: assert property (
      (ce && local_hit && req_write) |=>
      resp_valid && resp_write && resp_data == 32'h00000000)
    else $error("write answered with wrong flags or data");

  // protection of the contents
  a_powered_down: assert property (
      (ce && local_hit && port_powered_down) |=>
      resp_valid && resp_data == 32'h00000000)
    else $error("powered-down port returned data");
  a_write_inert: assert property (
      (ce && local_hit && req_write) ##[1:2] local_read_of(OFF_FEATURES) |=>
      resp_data == 32'h1000051F)
    else $error("write altered a capability");
  a_unmapped_zero: assert property (
      (ce && local_hit && !req_write &&
      req_offset != OFF_ASSEMBLY_INFO && req_offset != OFF_FEATURES) |=>
      resp_data == 32'h00000000)
    else $error("unmapped offset returned data");
  a_idle_quiet: assert property (
      !ce |=>
      $stable(s_q))
    else $error("state moved with clock enable low");


  c_read_asm:  cover property (local_read_of(OFF_ASSEMBLY_INFO) ##1 resp_valid);
  c_read_feat: cover property (local_read_of(OFF_FEATURES) ##1 resp_valid);
  c_route:     cover property (ce && req_valid && !local_hit ##1 route_valid);
  c_write:     cover property (ce && local_hit && req_write ##1 resp_write);
endmodule : switch_capability_car_bank

// ### remote_requester.sv
`timescale 1ns/1ns
module remote_requester (
  input  wire logic                          clk_sys,       // system clock
  output logic                               req_valid,     // request strobe
  output logic [3:0]                         req_ftype,     // format type
  output logic [7:0]                         req_hop_count, // hop count
  output logic                               req_write,     // write request
  output logic [car_bank_pkg::OFF_W-1:0]     req_offset,    // byte offset
  output logic [car_bank_pkg::REG_W-1:0]     req_wdata,     // write data
  input  wire logic                          resp_valid,    // answer pulse
  input  wire logic                          resp_write,    // answer is for a write
  input  wire logic [car_bank_pkg::REG_W-1:0] resp_data,    // read data
  input  wire logic                          route_valid    // passed on
);
  import car_bank_pkg::*;
  initial begin
    req_valid = 1'h0;
    req_ftype = 4'h0;
    req_hop_count = 8'hFF;
    req_write = 1'h0;
    req_offset = 24'h000000;
    req_wdata = 32'h00000000;
  end
  // one request, answer taken one edge after the request edge
  task automatic issue(input logic wr, input logic [3:0] ft, input logic [7:0] hop,
                       input logic [OFF_W-1:0] off, output logic [REG_W-1:0] data,
                       output logic [2:0] flags);
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_write <= wr;
    req_ftype <= ft;
    req_hop_count <= hop;
    req_offset <= off;
    req_wdata <= 32'hFFFFFFFF;
    @(posedge clk_sys);
    // released lines never keep the last value, so stale decode shows up
    req_valid <= 1'h0;
    req_write <= ~wr;
    req_ftype <= ~ft;
    req_hop_count <= ~hop;
    req_offset <= ~off;
    req_wdata <= 32'h00000000;
    @(negedge clk_sys);
    data = resp_data;
    flags = {resp_valid, resp_write, route_valid};
  endtask : issue
endmodule : remote_requester

// ### switch_capability_car_bank_test.sv
`timescale 1ns/1ns
module switch_capability_car_bank_test;
  import car_bank_pkg::*;
  logic                 clk_sys, rstn, ce, soft_reset, port_powered_down, preload_valid;
  logic [REV_W-1:0]     preload_value;
  logic                 req_valid, req_write, resp_valid, resp_write, route_valid;
  logic [3:0]           req_ftype;
  logic [7:0]           req_hop_count;
  logic [OFF_W-1:0]     req_offset;
  logic [REG_W-1:0]     req_wdata, resp_data, rd;
  logic [2:0]           fl;
  int                   miscompares, checks;
  switch_capability_car_bank switch_capability_car_bank_inst (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .soft_reset(soft_reset), .port_powered_down(port_powered_down),
    .preload_valid(preload_valid), .preload_value(preload_value), .req_valid(req_valid),
    .req_ftype(req_ftype), .req_hop_count(req_hop_count), .req_write(req_write),
    .req_offset(req_offset), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_write(resp_write), .resp_data(resp_data), .route_valid(route_valid));
  remote_requester remote_requester_inst (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_ftype(req_ftype), .req_hop_count(req_hop_count), .req_write(req_write),
    .req_offset(req_offset), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_write(resp_write), .resp_data(resp_data), .route_valid(route_valid));
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input string what, input logic [OFF_W-1:0] off, input logic [31:0] exp);
    remote_requester_inst.issue(1'h0, FTYPE_MAINT, HOP_LOCAL, off, rd, fl);
    check({what, "_flags"}, {29'h0, fl}, 32'h4);
    check(what, rd, exp);
  endtask : rd_chk
  task automatic wr_chk(input string what, input logic [OFF_W-1:0] off);
    remote_requester_inst.issue(1'h1, FTYPE_MAINT, HOP_LOCAL, off, rd, fl);
    check({what, "_flags"}, {29'h0, fl}, 32'h6);
    check(what, rd, 32'h0);
  endtask : wr_chk
  task automatic rt_chk(input string what, input logic [3:0] ft, input logic [7:0] hop);
    remote_requester_inst.issue(1'h0, ft, hop, OFF_FEATURES, rd, fl);
    check(what, {29'h0, fl}, 32'h1);
  endtask : rt_chk
  task automatic preload(input logic [REV_W-1:0] v);
    @(posedge clk_sys);
    preload_valid <= 1'h1;
    preload_value <= v;
    @(posedge clk_sys);
    preload_valid <= 1'h0;
    preload_value <= ~v;
  endtask : preload
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #(1000 * 50);
    miscompares++;
    conclude();
  end
  initial begin
    rstn = 1'h0;
    ce = 1'h1;
    soft_reset = 1'h0;
    port_powered_down = 1'h0;
    preload_valid = 1'h0;
    preload_value = 16'h0000;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'h1;
    rd_chk("asm_default", OFF_ASSEMBLY_INFO, 32'h00000100);
    rd_chk("features", OFF_FEATURES, 32'h1000051F);
    $display("test reset_values done");
    preload(16'hA5C3);
    rd_chk("asm_loaded", OFF_ASSEMBLY_INFO, 32'hA5C30100);
    preload(16'h5A3C);
    rd_chk("asm_second_load", OFF_ASSEMBLY_INFO, 32'hA5C30100);
    @(posedge clk_sys);
    soft_reset <= 1'h1;
    @(posedge clk_sys);
    soft_reset <= 1'h0;
    rd_chk("asm_after_soft", OFF_ASSEMBLY_INFO, 32'hA5C30100);
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    rd_chk("asm_after_por", OFF_ASSEMBLY_INFO, 32'h00000100);
    preload(16'h0F0F);
    rd_chk("asm_reloaded", OFF_ASSEMBLY_INFO, 32'h0F0F0100);
    $display("test preload done");
    wr_chk("write_asm", OFF_ASSEMBLY_INFO);
    wr_chk("write_feat", OFF_FEATURES);
    rd_chk("feat_after_write", OFF_FEATURES, 32'h1000051F);
    rd_chk("asm_after_write", OFF_ASSEMBLY_INFO, 32'h0F0F0100);
    rd_chk("unmapped", 24'h000014, 32'h00000000);
    $display("test writes done");
    rt_chk("route_ftype", 4'h5, HOP_LOCAL);
    rt_chk("route_hop", FTYPE_MAINT, 8'h01);
    $display("test routing done");
    @(posedge clk_sys);
    port_powered_down <= 1'h1;
    rd_chk("off_asm", OFF_ASSEMBLY_INFO, 32'h00000000);
    rd_chk("off_feat", OFF_FEATURES, 32'h00000000);
    @(posedge clk_sys);
    port_powered_down <= 1'h0;
    rd_chk("on_feat", OFF_FEATURES, 32'h1000051F);
    $display("test power_down done");
    // request while frozen: not taken, no answer appears
    @(posedge clk_sys);
    ce <= 1'h0;
    remote_requester_inst.issue(1'h0, FTYPE_MAINT, HOP_LOCAL, OFF_FEATURES, rd, fl);
    check("frozen_flags", {29'h0, fl}, 32'h0);
    check("frozen_data", rd, 32'h0);
    @(posedge clk_sys);
    ce <= 1'h1;
    rd_chk("thawed_feat", OFF_FEATURES, 32'h1000051F);
    $display("test clock_enable done");
    // soft reset right after power-on closes the window before any load
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    soft_reset <= 1'h1;
    @(posedge clk_sys);
    soft_reset <= 1'h0;
    preload(16'h3C3C);
    rd_chk("asm_soft_closed", OFF_ASSEMBLY_INFO, 32'h00000100);
    $display("test soft_closed done");
    conclude();
  end
endmodule : switch_capability_car_bank_test
